/* File: dpu_pkg.sv */
`default_nettype none

package dpu_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0]  IDX_PTR_LO  = 8'h82;
  localparam logic [7:0]  IDX_PTR_HI  = 8'h83;
  localparam logic [7:0]  IDX_AUX     = 8'ha2;
  localparam logic [11:0] ADDR_PTR_LO = {2'h0, IDX_PTR_LO, 2'h0};
  localparam logic [11:0] ADDR_PTR_HI = {2'h0, IDX_PTR_HI, 2'h0};
  localparam logic [11:0] ADDR_AUX    = {2'h0, IDX_AUX, 2'h0};

  // ----------------------------------------
  // Auxiliary control fields and reset values
  // ----------------------------------------
  localparam int          AUX_SEL_BIT  = 0;
  localparam int          AUX_ZERO_BIT = 1;
  localparam int          AUX_FLAG_BIT = 3;
  localparam logic [7:0]  AUX_WR_MASK  = 8'hed;
  localparam logic [7:0]  AUX_RST      = 8'h00;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  localparam logic [15:0] PTR_STEP     = 16'h0001;
  localparam logic [7:0]  AUX_STEP     = 8'h01;

  // ----------------------------------------
  // Bus responses and register selection
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_LO,
    REG_HI,
    REG_AUX
  } dpu_reg_t;

endpackage : dpu_pkg

`default_nettype wire

/* File: dpu_ptr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface dpu_ptr_if;
  logic        sel;
  logic        sel_nxt;
  logic        wr_lo;
  logic        wr_hi;
  logic        inc;
  logic [7:0]  wdata;
  logic [15:0] act;
  logic [15:0] ptr0;
  logic [15:0] ptr1;

  modport ctrl (
    output sel, sel_nxt, wr_lo, wr_hi, inc, wdata,
    input  act, ptr0, ptr1
  );

  modport bank (
    input  sel, sel_nxt, wr_lo, wr_hi, inc, wdata,
    output act, ptr0, ptr1
  );
endinterface : dpu_ptr_if

`default_nettype wire

/* File: dpu_ptr_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module dpu_ptr_bank (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Control side
  dpu_ptr_if.bank  bus
);

  // ----------------------------------------
  // Pointer storage
  // ----------------------------------------
  logic [15:0] ptr_r   [2];
  logic [15:0] ptr_nxt [2];
  logic [15:0] act_r;
  logic [15:0] act_nxt;
  logic [15:0] cur_ptr;

  always_comb begin
    ptr_nxt = ptr_r;
    for (int i = 0; i < 2; i++) begin
      if (bus.sel == 1'(i)) begin
        if (bus.wr_lo) begin
          ptr_nxt[i][7:0] = bus.wdata;
        end else if (bus.wr_hi) begin
          ptr_nxt[i][15:8] = bus.wdata;
        end else if (bus.inc) begin
          ptr_nxt[i] = ptr_r[i] + dpu_pkg::PTR_STEP;
        end
      end
    end
    act_nxt = bus.sel_nxt ? ptr_nxt[1] : ptr_nxt[0];
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r <= '{dpu_pkg::PTR_RST, dpu_pkg::PTR_RST};
      act_r <= dpu_pkg::PTR_RST;
    end else begin
      ptr_r <= ptr_nxt;
      act_r <= act_nxt;
    end
  end

  assign bus.act  = act_r;
  assign bus.ptr0 = ptr_r[0];
  assign bus.ptr1 = ptr_r[1];
  assign cur_ptr  = bus.sel ? ptr_r[1] : ptr_r[0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  inactive_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    1'b1 |=> ($past(bus.sel) ? (bus.ptr0 == $past(bus.ptr0)) : (bus.ptr1 == $past(bus.ptr1))))
    else $error("inactive pointer changed");

  ptr_inc_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (bus.inc && !bus.wr_lo && !bus.wr_hi) |=>
      (($past(bus.sel) ? bus.ptr1 : bus.ptr0) == $past(cur_ptr) + dpu_pkg::PTR_STEP))
    else $error("pointer increment wrong");

endmodule : dpu_ptr_bank

`default_nettype wire

/* File: dpu_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dpu_top (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // AXI4-Lite write address
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [11:0] i_s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [11:0] i_s_axi_araddr,
  // AXI4-Lite read data
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  // Core operations
  input  wire logic        i_ptr_inc,
  input  wire logic        i_aux_inc,
  // Core view
  output logic [15:0]      o_data_ptr,
  output logic             o_ptr_sel,
  output logic             o_user_flag
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic dpu_pkg::dpu_reg_t reg_decode(input logic [11:0] addr);
    dpu_pkg::dpu_reg_t res;
    res = dpu_pkg::REG_NONE;
    if (addr[11:2] == dpu_pkg::ADDR_PTR_LO[11:2]) begin
      res = dpu_pkg::REG_LO;
    end else if (addr[11:2] == dpu_pkg::ADDR_PTR_HI[11:2]) begin
      res = dpu_pkg::REG_HI;
    end else if (addr[11:2] == dpu_pkg::ADDR_AUX[11:2]) begin
      res = dpu_pkg::REG_AUX;
    end
    return res;
  endfunction : reg_decode

  // ----------------------------------------
  // Write channel state
  // ----------------------------------------
  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [11:0] awaddr_r;
  logic [11:0] awaddr_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic        lane0_r;
  logic        lane0_nxt;
  logic        awready_r;
  logic        awready_nxt;
  logic        wready_r;
  logic        wready_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        wr_go;
  dpu_pkg::dpu_reg_t wr_reg;

  assign wr_go  = aw_held_r && w_held_r;
  assign wr_reg = reg_decode(awaddr_r);

  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    lane0_nxt   = lane0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (i_s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = i_s_axi_wdata;
      lane0_nxt  = i_s_axi_wstrb[0];
    end
    if (bvalid_r && i_s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_reg == dpu_pkg::REG_NONE) ? dpu_pkg::RESP_SLVERR : dpu_pkg::RESP_OKAY;
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 12'h000;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      lane0_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= dpu_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      lane0_r   <= lane0_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // ----------------------------------------
  // Auxiliary control register
  // ----------------------------------------
  logic [7:0] aux_r;
  logic [7:0] aux_nxt;
  logic       wr_aux;

  assign wr_aux = wr_go && lane0_r && (wr_reg == dpu_pkg::REG_AUX);

  always_comb begin
    aux_nxt = aux_r;
    if (wr_aux) begin
      aux_nxt = wdata_r[7:0] & dpu_pkg::AUX_WR_MASK;
    end else if (i_aux_inc) begin
      aux_nxt = (aux_r + dpu_pkg::AUX_STEP) & dpu_pkg::AUX_WR_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aux_r <= dpu_pkg::AUX_RST;
    end else begin
      aux_r <= aux_nxt;
    end
  end

  // ----------------------------------------
  // Pointer bank
  // ----------------------------------------
  dpu_ptr_if ifc ();

  assign ifc.sel     = aux_r[dpu_pkg::AUX_SEL_BIT];
  assign ifc.sel_nxt = aux_nxt[dpu_pkg::AUX_SEL_BIT];
  assign ifc.wr_lo   = wr_go && lane0_r && (wr_reg == dpu_pkg::REG_LO);
  assign ifc.wr_hi   = wr_go && lane0_r && (wr_reg == dpu_pkg::REG_HI);
  assign ifc.inc     = i_ptr_inc;
  assign ifc.wdata   = wdata_r[7:0];

  dpu_ptr_bank dpu_ptr_bank_i (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .bus        (ifc.bank)
  );

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic        arready_r;
  logic        arready_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && i_s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (i_s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = dpu_pkg::RESP_OKAY;
      case (reg_decode(i_s_axi_araddr))
        dpu_pkg::REG_LO: begin
          rdata_nxt = {24'h00_0000, ifc.act[7:0]};
        end
        dpu_pkg::REG_HI: begin
          rdata_nxt = {24'h00_0000, ifc.act[15:8]};
        end
        dpu_pkg::REG_AUX: begin
          rdata_nxt = {24'h00_0000, aux_r & dpu_pkg::AUX_WR_MASK};
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = dpu_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= dpu_pkg::RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready  = wready_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_s_axi_rresp   = rresp_r;
  assign o_data_ptr      = ifc.act;
  assign o_ptr_sel       = aux_r[dpu_pkg::AUX_SEL_BIT];
  assign o_user_flag     = aux_r[dpu_pkg::AUX_FLAG_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic seen_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking

  default disable iff (!i_arst_n);

  reset_zero_a: assert property (
    !seen_r |-> (o_data_ptr == dpu_pkg::PTR_RST) && !o_ptr_sel)
    else $error("pointer not zero after reset");

  sel_map_a: assert property (
    o_data_ptr == (o_ptr_sel ? ifc.ptr1 : ifc.ptr0))
    else $error("active pointer does not follow select");

  zero_bit_a: assert property (
    (wr_aux && wdata_r[dpu_pkg::AUX_ZERO_BIT]) |=> !aux_r[dpu_pkg::AUX_ZERO_BIT])
    else $error("hard-wired zero bit was set");

  aux_toggle_a: assert property (
    (i_aux_inc && !wr_aux) |=>
      (o_ptr_sel != $past(o_ptr_sel)) && (aux_r[7:1] == $past(aux_r[7:1])))
    else $error("increment did not toggle select alone");

  flag_rw_a: assert property (
    wr_aux |=> (o_user_flag == $past(wdata_r[dpu_pkg::AUX_FLAG_BIT])))
    else $error("user flag not stored");

  lo_write_a: assert property (
    (ifc.wr_lo && !i_aux_inc) |=>
      (o_data_ptr[7:0] == $past(wdata_r[7:0])) && (o_data_ptr[15:8] == $past(o_data_ptr[15:8])))
    else $error("low byte write wrong");

  hi_write_a: assert property (
    (ifc.wr_hi && !i_aux_inc) |=>
      (o_data_ptr[15:8] == $past(wdata_r[7:0])) && (o_data_ptr[7:0] == $past(o_data_ptr[7:0])))
    else $error("high byte write wrong");

  wr_resp_a: assert property (
    (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready) |=> ##1 o_s_axi_bvalid)
    else $error("write response late");

  rd_resp_a: assert property (
    (i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read response late");

  upper_zero_a: assert property (
    o_s_axi_rvalid |-> (o_s_axi_rdata[31:8] == 24'h00_0000))
    else $error("upper read data not zero");

  ptr_idle_a: assert property (
    (!ifc.wr_lo && !ifc.wr_hi && !i_ptr_inc) |=>
      (ifc.ptr0 == $past(ifc.ptr0)) && (ifc.ptr1 == $past(ifc.ptr1)))
    else $error("pointer changed without operation");

  wr_refuse_a: assert property (
    o_s_axi_bvalid |-> (!o_s_axi_awready && !o_s_axi_wready))
    else $error("write taken while response pending");

  rd_refuse_a: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while data pending");

  toggle_c: cover property (i_aux_inc && o_ptr_sel ##1 !o_ptr_sel);
  carry_c:  cover property (i_ptr_inc && (o_data_ptr[7:0] == 8'hff));
  lo_wr_c:  cover property (ifc.wr_lo && o_ptr_sel);
  bad_rd_c: cover property (o_s_axi_rvalid && (o_s_axi_rresp == dpu_pkg::RESP_SLVERR));
  wrap_c:   cover property (i_ptr_inc && (o_data_ptr == 16'hffff));

endmodule : dpu_top

`default_nettype wire

/* File: dpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dpu_core_model (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  // Core operations
  output logic      o_ptr_inc,
  output logic      o_aux_inc
);
  // ------------------------------
  // Operation strobes
  // ------------------------------
  initial begin
    o_ptr_inc = 1'b0;
    o_aux_inc = 1'b0;
  end

  // Strobe held n cycles, one step per cycle
  task automatic step(input bit aux, input int n);
    wait (i_arst_n === 1'b1);
    @(posedge i_core_clk);
    if (aux) begin
      o_aux_inc <= 1'b1;
    end else begin
      o_ptr_inc <= 1'b1;
    end
    repeat (n) @(posedge i_core_clk);
    o_aux_inc <= 1'b0;
    o_ptr_inc <= 1'b0;
  endtask : step
endmodule : dpu_core_model

`default_nettype wire

/* File: dual_data_pointer_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dual_data_pointer_unit_tb;
  // ------------------------------
  // Signals and reference state
  // ------------------------------
  logic        core_clk, arst_n;
  logic        awv, wv, bre, arv, rre;
  logic        awrdy, wrdy, bv, arrdy, rv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [3:0]  ws, wst;
  logic [1:0]  bresp, rresp;
  logic [15:0] data_pointer_zero;
  logic        psel, uflag, pinc, ainc;
  logic [15:0] mp [2];
  logic [7:0]  maux;
  logic [11:0] adr [4];
  logic [33:0] rd_q [$];
  logic [1:0]  wr_q [$];
  logic [33:0] exp_r;
  int          errors, total_checks, cyc;

  dpu_top dpu_top_i (
    .i_core_clk(core_clk), .i_arst_n(arst_n),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arrdy), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .i_ptr_inc(pinc), .i_aux_inc(ainc),
    .o_data_ptr(data_pointer_zero), .o_ptr_sel(psel), .o_user_flag(uflag)
  );

  dpu_core_model dpu_core_model_i (
    .i_core_clk(core_clk), .i_arst_n(arst_n), .o_ptr_inc(pinc), .o_aux_inc(ainc)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ------------------------------
  // Comparison and verdict
  // ------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  // Oldest note against each bus answer
  always @(negedge core_clk) begin
    if (rv === 1'b1 && rre === 1'b1) begin
      exp_r = rd_q.pop_front();
      check({rresp, rdata}, exp_r);
    end
    if (bv === 1'b1 && bre === 1'b1) begin
      check(34'(bresp), 34'(wr_q.pop_front()));
    end
  end

  // ------------------------------
  // Bus and core tasks
  // ------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit ok, da, dw, ta, tw;
    ok = (a == adr[0]) || (a == adr[1]) || (a == adr[2]);
    wr_q.push_back(ok ? dpu_pkg::RESP_OKAY : dpu_pkg::RESP_SLVERR);
    if (ok && wst[0]) begin
      if (a == adr[0]) mp[maux[0]][7:0] = d;
      else if (a == adr[1]) mp[maux[0]][15:8] = d;
      else maux = d & dpu_pkg::AUX_WR_MASK;
    end
    da = 1'b0;
    dw = 1'b0;
    @(posedge core_clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    awa <= a;
    wd  <= {24'h0, d};
    ws  <= wst;
    while (!(da && dw)) begin
      @(negedge core_clk);
      ta = !da && awrdy === 1'b1;
      tw = !dw && wrdy === 1'b1;
      @(posedge core_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge core_clk); while (bv !== 1'b1);
    @(posedge core_clk);
    bre <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    if (a == adr[0]) rd_q.push_back({dpu_pkg::RESP_OKAY, 24'h0, mp[maux[0]][7:0]});
    else if (a == adr[1]) rd_q.push_back({dpu_pkg::RESP_OKAY, 24'h0, mp[maux[0]][15:8]});
    else if (a == adr[2]) rd_q.push_back({dpu_pkg::RESP_OKAY, 24'h0, maux});
    else rd_q.push_back({dpu_pkg::RESP_SLVERR, 32'h0});
    @(posedge core_clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do @(negedge core_clk); while (arrdy !== 1'b1);
    @(posedge core_clk);
    arv <= 1'b0;
    do @(negedge core_clk); while (rv !== 1'b1);
    @(posedge core_clk);
    rre <= 1'b0;
  endtask : rd

  task automatic op(input bit aux, input int n);
    dpu_core_model_i.step(aux, n);
    if (aux) maux[0] = maux[0] ^ n[0];
    else mp[maux[0]] = mp[maux[0]] + 16'(n);
  endtask : op

  task automatic core_chk();
    @(negedge core_clk);
    check(34'(data_pointer_zero), 34'(mp[maux[0]]));
    check(34'(psel), 34'(maux[0]));
    check(34'(uflag), 34'(maux[3]));
  endtask : core_chk

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(32'h3841743d));
    {arst_n, awv, wv, bre, arv, rre} = '0;
    {awa, ara, wd} = '0;
    ws = 4'hf;
    wst = 4'hf;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    mp[0] = dpu_pkg::PTR_RST;
    mp[1] = dpu_pkg::PTR_RST;
    maux = dpu_pkg::AUX_RST;
    adr = '{dpu_pkg::ADDR_PTR_LO, dpu_pkg::ADDR_PTR_HI, dpu_pkg::ADDR_AUX, 12'h100};
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    core_chk();
    for (int k = 0; k < 3; k++) rd(adr[k]);
    // Alternate pointers with random contents
    for (int i = 0; i < 6; i++) begin
      wr(adr[2], (8'($urandom) & 8'hfe) | 8'(i & 1));
      rd(adr[0]);
      rd(adr[1]);
      wr(adr[0], 8'($urandom));
      wr(adr[1], 8'($urandom));
      core_chk();
      for (int k = 0; k < 3; k++) rd(adr[k]);
    end
    wr(adr[2], 8'hff);
    rd(adr[2]);
    core_chk();
    // Toggle by increment, back to back
    op(1'b1, 1);
    core_chk();
    rd(adr[2]);
    rd(adr[0]);
    op(1'b1, 2);
    core_chk();
    // Carry and wrap of the active pointer
    wr(adr[0], 8'hff);
    wr(adr[1], 8'h00);
    op(1'b0, 1);
    core_chk();
    wr(adr[0], 8'hff);
    wr(adr[1], 8'hff);
    op(1'b0, 3);
    core_chk();
    rd(adr[0]);
    rd(adr[1]);
    op(1'b1, 1);
    core_chk();
    rd(adr[0]);
    // Unmapped place and disabled strobe
    wr(adr[3], 8'h5a);
    rd(adr[3]);
    wst = 4'h0;
    wr(adr[0], 8'h33);
    wst = 4'hf;
    rd(adr[0]);
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule : dual_data_pointer_unit_tb

`default_nettype wire
